//--- logic/sspg_top.sv
// What this block does
// - Until active, unused pins float pulled up; storage held reset.
// - Chained devices go active together on one config clock edge.
// - Logic runs during configuration; storage reset, outputs off.
// - Activate on rising config clock edge; outputs start together.
// - Activation is async to system clock, so make a synced pulse.
// - Flip-flop accepts a clock edge within 0.2 ns after reset ends.
// - Config pin low forces flip-flop input high; Q low, net high.
// - After configuration the function generator holds D as a latch.
// - First system clock after configuration sets Q, net driven low.
// - Chip-wide reset clears Q, releasing the net to its pull-up.
// - Only one pulse: high config pin stops the latch setting again.
// - Built from one logic block and one io block; pin not general I/O.
`timescale 1ns/1ps
`include "sspg_defs.svh"

module sspg_top
    import sspg_pkg::*;
(
    input  wire logic mclk,                  // System clock, 50 MHz
    input  wire logic rst,                   // Power-on reset, async high
    input  wire logic ce,                    // Clock enable, freezes state
    input  wire logic config_active,         // Device configuration running
    input  wire logic reset_net_in,          // Level seen on board reset net
    output sspg_pin_t low_during_config_pin, // Config pin drive
    output sspg_pin_t reset_net,             // Board reset net, open drain
    output logic      chip_reset_ff,         // Internal global reset to core
    output logic      core_ready_ff          // Core may be clocked
);

    sspg_state_t            state_ff;
    sspg_state_t            nxt_state;
    logic                   latch_ff;
    logic                   nxt_latch;
    logic                   q_ff;
    logic                   nxt_q;
    logic [`SSPG_CNT_W-1:0] recover_ff;
    logic [`SSPG_CNT_W-1:0] nxt_recover;
    logic                   chip_hold;
    logic                   cfg_pin_low;
    logic                   d_in;
    logic                   nxt_drive;
    logic                   nxt_ready;

    // Pin low exactly while configuration runs; it is spent on this job
    assign cfg_pin_low = config_active;

    // Storage is held while configuring or while the net is low
    assign chip_hold = config_active | ~reset_net_in;

    // Function generator: pin low forces D, otherwise an R-S latch
    // that only Q can clear
    assign d_in = cfg_pin_low | (latch_ff & ~q_ff);

    // Latch can only be set while the pin is low
    always_comb
    begin
        nxt_latch = d_in;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            latch_ff <= 1'h0;
        else if (ce)
            latch_ff <= nxt_latch;
    end

    // Q follows the latch unless the chip-wide reset holds it
    always_comb
    begin
        if (chip_hold)
        begin
            nxt_q = 1'h0;
        end
        else
        begin
            nxt_q = latch_ff;
        end
    end

    // System clock only: a config clock here would lose the alignment
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            q_ff <= 1'h0;
        else if (ce)
            q_ff <= nxt_q;
    end

    // Sequence tracker; RUNNING keeps a second pulse from starting
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            SSPG_CONFIG:
            begin
                if (!config_active)
                    nxt_state = SSPG_ARMED;
            end
            SSPG_ARMED:
            begin
                if (latch_ff && !config_active)
                    nxt_state = SSPG_PULSE;
            end
            SSPG_PULSE:
            begin
                if (!q_ff)
                    nxt_state = SSPG_RUNNING;
            end
            SSPG_RUNNING:
            begin
                if (config_active)
                    nxt_state = SSPG_CONFIG;
            end
            default:
            begin
                nxt_state = SSPG_CONFIG;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_ff <= SSPG_CONFIG;
        else if (ce)
            state_ff <= nxt_state;
    end

    // Recovery counter: an edge sooner after the net rises may be
    // missed by the core flip-flops
    always_comb
    begin
        nxt_recover = recover_ff;
        if (chip_hold)
            nxt_recover = `SSPG_RECOVER_LOAD;
        else if (recover_ff != `SSPG_ZERO_CNT)
            nxt_recover = recover_ff - `SSPG_ONE_CNT;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            recover_ff <= `SSPG_RECOVER_LOAD;
        else if (ce)
            recover_ff <= nxt_recover;
    end

    // Internal reset: all storage held while configuring or net low
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            chip_reset_ff <= 1'h1;
        else if (ce)
            chip_reset_ff <= chip_hold;
    end

    // Internal reset recovery is far below one clock, so the ready
    // flag register adds just one cycle beyond the external count
    always_comb
    begin
        nxt_ready = 1'h0;
        if (!chip_hold && recover_ff == `SSPG_ZERO_CNT)
            nxt_ready = 1'h1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            core_ready_ff <= 1'h0;
        else if (ce)
            core_ready_ff <= nxt_ready;
    end

    // Net driven low on the same edge that sets Q; dropped as soon as
    // the low net is seen, so the pulse is one clock long
    always_comb
    begin
        nxt_drive = 1'h0;
        if (!chip_hold && latch_ff && d_in && state_ff != SSPG_RUNNING)
            nxt_drive = 1'h1;
    end

    // Pins: config pin level and net enable change on the same edge at activation
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reset_net             <= '{o: 1'h0, oe: 1'h0};
            low_during_config_pin <= '{o: 1'h0, oe: 1'h1};
        end
        else if (ce)
        begin
            reset_net             <= '{o: 1'h0, oe: nxt_drive};
            low_during_config_pin <= '{o: ~config_active,
                                       oe: 1'h1};
        end
    end

endmodule

//--- logic/sspg_defs.svh
`ifndef SSPG_DEFS_SVH
`define SSPG_DEFS_SVH

// Recovery figures, time in picoseconds as printed, and the clock period
`define SSPG_CLK_PERIOD_PS    20000
`define SSPG_RD_RECOVER_PS    200
`define SSPG_EXT_RECOVER_PS   25000
// Least time rounds up
`define SSPG_EXT_RECOVER_CYC  \
    ((`SSPG_EXT_RECOVER_PS + `SSPG_CLK_PERIOD_PS - 1) / `SSPG_CLK_PERIOD_PS)
`define SSPG_CNT_W            3
`define SSPG_RECOVER_LOAD     `SSPG_CNT_W'(`SSPG_EXT_RECOVER_CYC)
`define SSPG_ZERO_CNT         3'h0
`define SSPG_ONE_CNT          3'h1

`endif

//--- logic/sspg_pkg.sv
package sspg_pkg;

    typedef enum logic [1:0] {
        SSPG_CONFIG  = 2'b00,  // Configuration running, storage reset
        SSPG_ARMED   = 2'b01,  // Configuration done, latch set
        SSPG_PULSE   = 2'b10,  // Pulse over, net released; waits for Q to clear
        SSPG_RUNNING = 2'b11   // Pulse done, latch stays clear until configuration restarts
    } sspg_state_t;

    typedef struct packed {
        logic o;    // Level driven onto the pin
        logic oe;   // High while this block drives the pin
    } sspg_pin_t;

endpackage

//--- test/sspg_board.sv
`timescale 1ns/1ps
module sspg_board import sspg_pkg::*; (
    input  sspg_pin_t drv, // Block drive
    output logic      net  // Net level
);
    assign net = !(drv.oe && !drv.o); // Pull-up when released
endmodule

//--- test/sspg_top_monitor.sv
`timescale 1ns/1ps
module sspg_top_monitor import sspg_pkg::*; (
    input wire logic mclk,          // Clock
    input wire logic rst,           // Reset
    input wire logic config_active, // Config
    input wire logic reset_net_in,  // Net
    input sspg_pin_t low_during_config_pin, // Pin
    input sspg_pin_t reset_net,     // Drive
    input wire logic chip_reset_ff, // Core reset
    input wire logic core_ready_ff  // Ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_wait; !core_ready_ff [*3] ##[1:3] core_ready_ff; endsequence
    cfg_pin_a: assert property
        (low_during_config_pin.oe
         && low_during_config_pin.o == !$past(config_active))
        else $error("pin");
    drain_a: assert property
        (reset_net.o == 1'h0) else $error("drain");
    cfg_quiet_a: assert property
        (config_active |=> !reset_net.oe && !core_ready_ff) else $error("cfg");
    pulse_go_a: assert property
        ($fell(config_active) |-> ##[1:2] reset_net.oe) else $error("start");
    pulse_end_a: assert property
        ($rose(reset_net.oe) |=> !reset_net.oe) else $error("width");
    core_rst_a: assert property
        (!reset_net_in |-> ##[1:2] chip_reset_ff) else $error("reset");
    one_pulse_a: assert property
        ($fell(reset_net.oe) |=> (!reset_net.oe || config_active) [*8])
        else $error("again");
    ready_wait_a: assert property
        ($rose(reset_net_in) |-> s_wait) else $error("ready");
endmodule
bind sspg_top sspg_top_monitor mon (.mclk, .rst, .config_active,
    .reset_net_in, .low_during_config_pin, .reset_net, .chip_reset_ff,
    .core_ready_ff);

//--- test/sspg_top_tb.sv
`timescale 1ns/1ps
module sspg_top_tb import sspg_pkg::*;;
    logic      mclk, rst, ce, cfg, net, crst, rdy;
    sspg_pin_t cfg_pin, drv;
    int        err_total, cmp_count, pulses, q[$], gap = -1;
    int        n = $urandom(20208);
    sspg_top sspg_top_inst (.mclk, .rst, .ce, .config_active(cfg),
        .reset_net_in(net), .low_during_config_pin(cfg_pin), .reset_net(drv),
        .chip_reset_ff(crst), .core_ready_ff(rdy));
    sspg_board sspg_board_inst (.drv, .net);
    task automatic chk(input logic [7:0] seen, want);
        cmp_count++;
        err_total += (seen !== want);
        if (seen !== want) $display("wrong value at %0t: %h", $time, seen);
    endtask
    task automatic tally_and_finish;
        $display("%0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial forever #10 mclk = ~mclk;
    // Cycles from net release to core ready
    always @(posedge mclk)
    begin
        pulses += (drv.oe === 1'h1);
        gap = $rose(net) ? 0 : gap + (gap >= 0);
        if (rdy === 1'h1 && gap >= 0) chk(gap, q.pop_front());
        if (rdy === 1'h1) gap = -1;
    end
    initial
    begin
        {mclk, rst, ce, cfg} = 4'h7;
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        for (int t = 1; t <= 3; t++)
        begin
            repeat ($urandom_range(8, 1)) @(posedge mclk);
            #1 chk(cfg_pin.o, 1'h0);
            q.push_back((25 + 19) / 20 + 1);
            @(posedge mclk) cfg <= 1'h0;
            for (n = 0; n < 50 && rdy !== 1'h1; n++) @(posedge mclk);
            err_total += (n == 50);
            if (n == 50) tally_and_finish;
            repeat (20) @(posedge mclk);
            #1 chk(pulses, t);
            chk(cfg_pin.o, 1'h1);
            $display("test %0d done", t);
            @(posedge mclk) cfg <= 1'h1;
        end
        tally_and_finish;
    end
endmodule
